// *** duart_regs.sv ***
/*
  One channel register bank of a dual serial port, decoded from three address lines.
  Assumes the host bus strobes are already synchronous to clk, one-cycle per access.
*/
// Function
// - Each channel owns its registers; three address lines choose the register.
// - Chip or channel select picks the channel; only that channel responds.
// - Offset 0 normal bank: read receive holding, write transmit holding.
// - Divisor bank, not unlock: offsets 0 and 1 are divisor low and high.
// - Divisor bank offset 2: alternate function if enhanced bit 4 clear, else fraction.
// - Divisor bank with divisor zero: reads at 0 and 1 give revision and ident.
// - Offset 2 normal bank: read interrupt status, write FIFO control.
// - Unlock value: offset 2 enhanced feature, offsets 4 to 7 flow characters.
// - Offset 5 reads line status only outside unlock.
// - Offset 6 reads modem status only outside unlock.
// - Offset 7 is a plain scratch register outside unlock.
// - Offset 3 always reaches the line control register.
// - Offset 4 reaches modem control outside unlock.
// - Offset 1 normal bank reaches interrupt enable.
// - Enhanced bits of four registers work only with enhanced bit 4 set.
`timescale 1ns/1ps
`include "duart_defines.svh"

module duart_regs
(
  input  wire logic                  clk,
  input  wire logic                  rst_n,
  input  wire logic                  ce,
  input  wire logic                  chan_sel,
  input  wire duart_pkg::duart_req_t req,
  input  wire duart_pkg::duart_stat_t stat,
  output logic      [7:0]            rdata,
  output logic                       rx_pop,
  output logic                       tx_push,
  output logic      [7:0]            tx_data,
  output logic                       fifo_ctl_wr,
  output logic      [7:0]            fifo_ctl_data,
  output logic                       line_stat_rd,
  output logic                       modem_stat_rd,
  output duart_pkg::duart_cfg_t      cfg
);
  import duart_pkg::*;

  // ----------------------------------------------------------------
  // Register storage
  // ----------------------------------------------------------------
  logic [7:0] int_en_q, line_ctl_q, modem_ctl_q, div_lo_q, div_hi_q, div_frac_q, alt_fn_q, enh_feat_q, scratch_q;
  logic [7:0] xon1_q, xon2_q, xoff1_q, xoff2_q;
  logic [7:0] rdata_q, tx_data_q, fifo_ctl_data_q;
  logic       rx_pop_q, tx_push_q, fifo_ctl_wr_q, line_stat_rd_q, modem_stat_rd_q;

  // ----------------------------------------------------------------
  // Bank decode
  // ----------------------------------------------------------------
  wire         unlock     = (line_ctl_q == `DUART_UNLOCK_VAL);
  wire         div_en     = line_ctl_q[`DUART_LINE_DIV_BIT];
  wire         enh        = enh_feat_q[`DUART_ENH_ON_BIT];
  wire         div_zero   = (div_lo_q == 8'h00) && (div_hi_q == 8'h00);
  wire duart_bank_t bank  = unlock ? DUART_BANK_ENHANCED :
                            (div_en ? DUART_BANK_DIVISOR : DUART_BANK_NORMAL);
  wire         acc_rd     = ce && chan_sel && req.rd;
  wire         acc_wr     = ce && chan_sel && req.wr;
  wire [7:0]   sel        = 8'h01 << req.addr;
  wire [7:0]   int_en_mask    = enh ? 8'hff : ~`DUART_INTEN_ENH_MASK;
  wire [7:0]   isf_mask       = enh ? 8'hff : ~`DUART_ISF_ENH_MASK;
  wire [7:0]   fifo_ctl_mask  = enh ? 8'hff : ~`DUART_FIFOCTL_ENH_MASK;
  wire [7:0]   modem_ctl_mask = enh ? 8'hff : ~`DUART_MODEMCTL_ENH_MASK;
  wire         nb         = (bank == DUART_BANK_NORMAL);
  wire         db         = (bank == DUART_BANK_DIVISOR);
  wire         eb         = (bank == DUART_BANK_ENHANCED);

  // Write strobes per register.
  wire w_tx        = acc_wr && sel[0] && nb;
  wire w_div_lo    = acc_wr && sel[0] && db;
  wire w_int_en    = acc_wr && sel[1] && nb;
  wire w_div_hi    = acc_wr && sel[1] && db;
  wire w_fifo_ctl  = acc_wr && sel[2] && nb;
  wire w_alt_fn    = acc_wr && sel[2] && db && !enh;
  wire w_div_frac  = acc_wr && sel[2] && db && enh;
  wire w_enh_feat  = acc_wr && sel[2] && eb;
  wire w_line_ctl  = acc_wr && sel[3];
  wire w_modem_ctl = acc_wr && sel[4] && !eb;
  wire w_xon1 = acc_wr && sel[4] && eb;
  wire w_xon2 = acc_wr && sel[5] && eb;
  wire w_xof1 = acc_wr && sel[6] && eb;
  wire w_scratch = acc_wr && sel[7] && !eb;
  wire w_xof2 = acc_wr && sel[7] && eb;

  // ----------------------------------------------------------------
  // Read data selection
  // ----------------------------------------------------------------
  logic [7:0] rd_mux;
  always_comb
  begin
    rd_mux = 8'h00;
    unique case (req.addr)
      `DUART_OFS_DATA:
        if (nb) rd_mux = stat.rx_data;
        else if (db) rd_mux = div_zero ? `DUART_REV_CODE : div_lo_q;
      `DUART_OFS_IEN:
        if (nb) rd_mux = int_en_q & int_en_mask;
        else if (db) rd_mux = div_zero ? `DUART_ID_CODE : div_hi_q;
      `DUART_OFS_ISF:
        if (nb) rd_mux = stat.int_status & isf_mask;
        else if (db) rd_mux = enh ? (div_frac_q & `DUART_FRAC_MASK) : alt_fn_q;
        else rd_mux = enh_feat_q;
      `DUART_OFS_LINE:
        rd_mux = line_ctl_q;
      `DUART_OFS_MODEM:
        rd_mux = eb ? xon1_q : (modem_ctl_q & modem_ctl_mask);
      `DUART_OFS_LSTAT:
        rd_mux = eb ? xon2_q : stat.line_status;
      `DUART_OFS_MSTAT:
        rd_mux = eb ? xoff1_q : stat.modem_status;
      `DUART_OFS_SCRATCH:
        rd_mux = eb ? xoff2_q : scratch_q;
    endcase
  end

  wire r_rx         = acc_rd && sel[0] && nb;
  wire r_line_stat  = acc_rd && sel[5] && !eb;
  wire r_modem_stat = acc_rd && sel[6] && !eb;

  // ----------------------------------------------------------------
  // Configuration registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      int_en_q    <= `DUART_RST_BYTE;
      line_ctl_q  <= `DUART_RST_LINE;
      modem_ctl_q <= `DUART_RST_BYTE;
      div_lo_q    <= `DUART_RST_BYTE;
      div_hi_q    <= `DUART_RST_BYTE;
      div_frac_q  <= `DUART_RST_BYTE;
      alt_fn_q    <= `DUART_RST_BYTE;
      enh_feat_q  <= `DUART_RST_BYTE;
      scratch_q   <= `DUART_RST_BYTE;
      xon1_q  <= `DUART_RST_BYTE;
      xon2_q  <= `DUART_RST_BYTE;
      xoff1_q <= `DUART_RST_BYTE;
      xoff2_q <= `DUART_RST_BYTE;
    end
    else if (ce)
    begin
      if (w_int_en)    int_en_q    <= req.wdata & int_en_mask;
      if (w_line_ctl)  line_ctl_q  <= req.wdata;
      if (w_modem_ctl) modem_ctl_q <= req.wdata & modem_ctl_mask;
      if (w_div_lo)    div_lo_q    <= req.wdata;
      if (w_div_hi)    div_hi_q    <= req.wdata;
      if (w_div_frac)  div_frac_q  <= req.wdata & `DUART_FRAC_MASK;
      if (w_alt_fn)    alt_fn_q    <= req.wdata & `DUART_ALTFN_MASK;
      if (w_enh_feat)  enh_feat_q  <= req.wdata;
      if (w_scratch)   scratch_q   <= req.wdata;
      if (w_xon1) xon1_q  <= req.wdata;
      if (w_xon2) xon2_q  <= req.wdata;
      if (w_xof1) xoff1_q <= req.wdata;
      if (w_xof2) xoff2_q <= req.wdata;
    end
  end

  // ----------------------------------------------------------------
  // Read data and side-effect strobes
  // ----------------------------------------------------------------
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      rdata_q     <= 8'h00;
      rx_pop_q    <= 1'b0;
      tx_push_q   <= 1'b0;
      tx_data_q   <= 8'h00;
      fifo_ctl_wr_q   <= 1'b0;
      fifo_ctl_data_q <= 8'h00;
      line_stat_rd_q  <= 1'b0;
      modem_stat_rd_q <= 1'b0;
    end
    else if (ce)
    begin
      if (acc_rd) rdata_q <= rd_mux;
      rx_pop_q        <= r_rx;
      tx_push_q       <= w_tx;
      fifo_ctl_wr_q   <= w_fifo_ctl;
      line_stat_rd_q  <= r_line_stat;
      modem_stat_rd_q <= r_modem_stat;
      if (w_tx)       tx_data_q       <= req.wdata;
      if (w_fifo_ctl) fifo_ctl_data_q <= req.wdata & fifo_ctl_mask;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign rdata     = rdata_q;
  assign rx_pop    = rx_pop_q;
  assign tx_push   = tx_push_q;
  assign tx_data   = tx_data_q;
  assign fifo_ctl_wr   = fifo_ctl_wr_q;
  assign fifo_ctl_data = fifo_ctl_data_q;
  assign line_stat_rd  = line_stat_rd_q;
  assign modem_stat_rd = modem_stat_rd_q;
  assign cfg       = '{interrupt_enable:  int_en_q,
                       line_control:      line_ctl_q,
                       modem_control:     modem_ctl_q,
                       baud_divisor_low:  div_lo_q,
                       baud_divisor_high: div_hi_q,
                       divisor_fraction:  div_frac_q,
                       alt_function:      alt_fn_q,
                       enhanced_feature:  enh_feat_q,
                       flow_on_char1:     xon1_q,
                       flow_on_char2:     xon2_q,
                       flow_off_char1:    xoff1_q,
                       flow_off_char2:    xoff2_q};

endmodule

// *** duart_defines.svh ***
/*
  Offsets, field positions, reset values and fixed codes for the serial channel register bank.
  Assumes inclusion by bare name from the register bank module and the testbench.
*/
`ifndef DUART_DEFINES_SVH
`define DUART_DEFINES_SVH

// ----------------------------------------------------------------
// Register offsets on the three address lines
// ----------------------------------------------------------------
`define DUART_OFS_DATA      3'h0
`define DUART_OFS_IEN       3'h1
`define DUART_OFS_ISF       3'h2
`define DUART_OFS_LINE      3'h3
`define DUART_OFS_MODEM     3'h4
`define DUART_OFS_LSTAT     3'h5
`define DUART_OFS_MSTAT     3'h6
`define DUART_OFS_SCRATCH   3'h7

// ----------------------------------------------------------------
// Field positions and masks
// ----------------------------------------------------------------
`define DUART_LINE_DIV_BIT  7
`define DUART_ENH_ON_BIT        4
`define DUART_UNLOCK_VAL        8'hbf
`define DUART_INTEN_ENH_MASK    8'hf0
`define DUART_ISF_ENH_MASK      8'h30
`define DUART_FIFOCTL_ENH_MASK  8'h30
`define DUART_MODEMCTL_ENH_MASK 8'he0
`define DUART_FRAC_MASK         8'h3f
`define DUART_ALTFN_MASK        8'h07

// ----------------------------------------------------------------
// Reset values and codes (identity codes are arbitrary)
// ----------------------------------------------------------------
`define DUART_RST_BYTE      8'h00
`define DUART_RST_LINE      8'h03
`define DUART_REV_CODE      8'h01
`define DUART_ID_CODE       8'h5a

`endif

// *** duart_pkg.sv ***
/*
  Types shared by the serial channel register bank.
  Assumes the defines header is available on the include path.
*/
package duart_pkg;

  // ----------------------------------------------------------------
  // Host bus request
  // ----------------------------------------------------------------
  typedef struct packed {
    logic       rd;
    logic       wr;
    logic [2:0] addr;
    logic [7:0] wdata;
  } duart_req_t;

  // ----------------------------------------------------------------
  // Status fed from the channel data path
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [7:0] rx_data;
    logic [7:0] int_status;
    logic [7:0] line_status;
    logic [7:0] modem_status;
  } duart_stat_t;

  // ----------------------------------------------------------------
  // Configuration handed to the channel data path
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [7:0] interrupt_enable;
    logic [7:0] line_control;
    logic [7:0] modem_control;
    logic [7:0] baud_divisor_low;
    logic [7:0] baud_divisor_high;
    logic [7:0] divisor_fraction;
    logic [7:0] alt_function;
    logic [7:0] enhanced_feature;
    logic [7:0] flow_on_char1;
    logic [7:0] flow_on_char2;
    logic [7:0] flow_off_char1;
    logic [7:0] flow_off_char2;
  } duart_cfg_t;

  typedef enum logic [1:0] {
    DUART_BANK_NORMAL,
    DUART_BANK_DIVISOR,
    DUART_BANK_ENHANCED
  } duart_bank_t;

endpackage

// *** duart_host.sv ***
/*
  Host bus model that makes register accesses on one channel.
  Assumes the register bank takes a request on the first rising clk edge it is seen.
*/
`timescale 1ns/1ps
module duart_host
(
  input  wire logic             clk,
  input  wire logic [7:0]       rdata,
  output logic                  ce,
  output logic                  chan_sel,
  output duart_pkg::duart_req_t req
);
  import duart_pkg::*;
  // ----------------------------------------------------------------
  // Bus cycles
  // ----------------------------------------------------------------
  initial
  begin
    ce = 1'b1;
    chan_sel = 1'b0;
    req = '0;
  end
  task automatic acc(input logic w, input logic [2:0] a, input logic [7:0] d, input logic s,
                     output logic [7:0] q);
    @(posedge clk);
    #1;
    chan_sel = s;
    req = '{rd: !w, wr: w, addr: a, wdata: d};
    @(posedge clk);
    #1;
    q = rdata;
    chan_sel = 1'b0;
    req = '{rd: 1'b0, wr: 1'b0, addr: ~a, wdata: ~d};
  endtask
  task automatic set_ce(input logic v);
    ce = v;
  endtask
endmodule

// *** duart_regs_checker.sv ***
/*
  Port assertions for the register bank.
  Assumes it is bound to every register bank instance.
*/
`timescale 1ns/1ps
module duart_regs_checker
(
  input wire logic                   clk,
  input wire logic                   rst_n,
  input wire logic                   ce,
  input wire logic                   chan_sel,
  input wire duart_pkg::duart_req_t  req,
  input wire duart_pkg::duart_stat_t stat,
  input wire logic [7:0]             rdata,
  input wire logic                   rx_pop,
  input wire logic                   tx_push,
  input wire logic [7:0]             tx_data,
  input wire logic                   fifo_ctl_wr,
  input wire logic [7:0]             fifo_ctl_data,
  input wire logic                   line_stat_rd,
  input wire logic                   modem_stat_rd,
  input wire duart_pkg::duart_cfg_t  cfg
);
  import duart_pkg::*;
  // ----------------------------------------------------------------
  // Decode helpers
  // ----------------------------------------------------------------
  wire       rd_t = ce && chan_sel && req.rd;
  wire       wr_t = ce && chan_sel && req.wr;
  wire [7:0] line_ctl = cfg.line_control;
  wire       nrm  = !line_ctl[7];
  wire       enh  = cfg.enhanced_feature[4];
  wire [7:0] emk  = enh ? 8'hff : 8'hcf;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  rx_read_a: assert property (rd_t && req.addr == 3'h0 && nrm |=>
    rx_pop && rdata == $past(stat.rx_data))
    else $error("receive read wrong");
  tx_write_a: assert property (wr_t && req.addr == 3'h0 && nrm |=>
    tx_push && tx_data == $past(req.wdata))
    else $error("transmit write wrong");
  fifo_write_a: assert property (wr_t && req.addr == 3'h2 && nrm |=>
    fifo_ctl_wr && fifo_ctl_data == ($past(req.wdata) & $past(emk)))
    else $error("fifo control write wrong");
  int_stat_read_a: assert property (rd_t && req.addr == 3'h2 && nrm |=>
    rdata == ($past(stat.int_status) & $past(emk)))
    else $error("interrupt status read wrong");
  line_stat_read_a: assert property (rd_t && req.addr == 3'h5 && line_ctl != 8'hbf |=>
    line_stat_rd && rdata == $past(stat.line_status))
    else $error("line status read wrong");
  modem_stat_read_a: assert property (rd_t && req.addr == 3'h6 && line_ctl != 8'hbf |=>
    modem_stat_rd && rdata == $past(stat.modem_status))
    else $error("modem status read wrong");
  line_write_a: assert property (wr_t && req.addr == 3'h3 |=> line_ctl == $past(req.wdata))
    else $error("line control write wrong");
  int_en_write_a: assert property (wr_t && req.addr == 3'h1 && nrm |=>
    cfg.interrupt_enable == ($past(req.wdata) & (enh ? 8'hff : 8'h0f)))
    else $error("interrupt enable write wrong");
  desel_idle_a: assert property (ce && !chan_sel |=>
    !rx_pop && !tx_push && !fifo_ctl_wr && !line_stat_rd && !modem_stat_rd && $stable(cfg))
    else $error("deselected access had effect");
  ce_freeze_a: assert property (!ce |=> $stable(cfg) && $stable(rdata) && $stable(tx_data))
    else $error("state changed with clock enable low");
endmodule
bind duart_regs duart_regs_checker i_chk (.clk, .rst_n, .ce, .chan_sel, .req, .stat, .rdata, .rx_pop, .tx_push,
  .tx_data, .fifo_ctl_wr, .fifo_ctl_data, .line_stat_rd, .modem_stat_rd, .cfg);

// *** testbench.sv ***
/*
  Self-checking bench for one channel register bank.
  Assumes the host model and the bound checker are compiled alongside.
*/
`timescale 1ns/1ps
`include "duart_defines.svh"
module testbench;
  import duart_pkg::*;
  // ----------------------------------------------------------------
  // Signals and instances
  // ----------------------------------------------------------------
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  duart_stat_t stat = '0;
  logic        ce, chan_sel, rx_pop, tx_push, fifo_ctl_wr, line_stat_rd, modem_stat_rd;
  duart_req_t  req;
  duart_cfg_t  cfg;
  logic [7:0]  rdata, tx_data, fifo_ctl_data, q, d;
  int          num_errors = 0;
  int          cmp_count = 0;
  int          cycles = 0;
  `define CHK(nm, e, g) begin cmp_count++; if ((g) !== (e)) begin num_errors++; \
    $display("[ERR] %s expected %h seen %h", nm, e, g); end end
  always #4 clk = ~clk;
  duart_regs i_dut (.clk(clk), .rst_n(rst_n), .ce(ce), .chan_sel(chan_sel), .req(req), .stat(stat),
    .rdata(rdata), .rx_pop(rx_pop), .tx_push(tx_push), .tx_data(tx_data), .fifo_ctl_wr(fifo_ctl_wr),
    .fifo_ctl_data(fifo_ctl_data), .line_stat_rd(line_stat_rd), .modem_stat_rd(modem_stat_rd), .cfg(cfg));
  duart_host i_host (.clk(clk), .rdata(rdata), .ce(ce), .chan_sel(chan_sel), .req(req));
  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic finish_test;
    $display("comparisons %0d mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic wr(input logic [2:0] a, input logic [7:0] v);
    i_host.acc(1'b1, a, v, 1'b1, q);
  endtask
  task automatic rchk(input string nm, input logic [2:0] a, input logic [7:0] e);
    i_host.acc(1'b0, a, 8'h00, 1'b1, q);
    `CHK(nm, e, q)
  endtask
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 3000)
    begin
      num_errors++;
      finish_test();
    end
  end
  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial
  begin
    void'($urandom(40));
    repeat (3) @(posedge clk);
    #1;
    rst_n = 1'b1;
    rchk("line_control", 3'h3, `DUART_RST_LINE);
    for (int i = 0; i < 4; i++)
    begin
      stat = $urandom;
      d = 8'($urandom);
      wr(3'h3, d & 8'h7f);
      rchk("line_control", 3'h3, d & 8'h7f);
      wr(3'h7, d);
      rchk("scratch_pad", 3'h7, d);
      wr(3'h4, d);
      rchk("modem_control", 3'h4, d & 8'h1f);
      wr(3'h1, d);
      rchk("interrupt_enable", 3'h1, d & 8'h0f);
      rchk("receive_holding", 3'h0, stat.rx_data);
      wr(3'h0, d);
      `CHK("tx_data", d, tx_data)
      wr(3'h2, d);
      `CHK("fifo_ctl_data", d & 8'hcf, fifo_ctl_data)
      rchk("interrupt_status", 3'h2, stat.int_status & 8'hcf);
      rchk("line_status", 3'h5, stat.line_status);
      rchk("modem_status", 3'h6, stat.modem_status);
      i_host.acc(1'b1, 3'h7, ~d, 1'b0, q);
      rchk("scratch_pad", 3'h7, d);
      i_host.set_ce(1'b0);
      i_host.acc(1'b1, 3'h7, ~d, 1'b1, q);
      i_host.set_ce(1'b1);
      rchk("scratch_pad", 3'h7, d);
      wr(3'h3, 8'h80);
      rchk("device_revision", 3'h0, `DUART_REV_CODE);
      rchk("device_ident", 3'h1, `DUART_ID_CODE);
      wr(3'h0, d | 8'h01);
      rchk("baud_divisor_low", 3'h0, d | 8'h01);
      wr(3'h1, d);
      rchk("baud_divisor_high", 3'h1, d);
      wr(3'h0, 8'h00);
      wr(3'h1, 8'h00);
      wr(3'h2, d);
      rchk("alt_function", 3'h2, d & 8'h07);
      wr(3'h3, 8'hbf);
      wr(3'h2, d | 8'h10);
      rchk("enhanced_feature", 3'h2, d | 8'h10);
      for (int j = 4; j < 8; j++)
      begin
        wr(3'(j), d ^ 8'(j));
        rchk("flow_char", 3'(j), d ^ 8'(j));
      end
      rchk("line_control", 3'h3, 8'hbf);
      wr(3'h3, 8'h80);
      wr(3'h2, d);
      rchk("divisor_fraction", 3'h2, d & 8'h3f);
      wr(3'h3, 8'h00);
      wr(3'h1, d);
      rchk("interrupt_enable", 3'h1, d);
      rchk("interrupt_status", 3'h2, stat.int_status);
      wr(3'h3, 8'hbf);
      wr(3'h2, 8'h00);
      $display("test %0d done", i);
    end
    finish_test();
  end
endmodule
